// File: hw/vsp_regmem.sv
/*
 * User register memory: 64 words of 16 bits, byte-lane writes,
 * registered read data.
 * Assumes requests arrive on clk_i from the port controller.
 */
`timescale 1ns/100ps
`default_nettype none
module vsp_regmem
    import vsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    vsp_mem_if.mem bus
);
    localparam int LANES = REG_W / BYTE_W;

    // One array per byte lane, so no two processes share a variable
    logic [BYTE_W-1:0] store [LANES][REG_CNT];
    logic [BYTE_W-1:0] rd_lane [LANES];

    ////////////////////////////////////////////////////////////////////////
    // Byte lanes written independently, read together on one read strobe
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            always_ff @(posedge clk_i) begin
                if (bus.be[g]) begin
                    store[g][bus.waddr] <= bus.wdata[g*BYTE_W +: BYTE_W];
                end
            end
            // Lane read data held in a register
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    rd_lane[g] <= BYTE_RST;
                end else if (bus.re) begin
                    rd_lane[g] <= store[g][bus.raddr];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Word assembled from the lane registers
    assign bus.rdata = {rd_lane[LANES-1], rd_lane[0]};
endmodule
`default_nettype wire

// File: hw/vsp_top.sv
/*
 * Four-wire serial slave port into the 16-bit user registers.
 * Assumes serial clock idles high (falling edge first), that the master
 * keeps chip select high for at least 8 clk_i cycles between frames,
 * and that the pad logic builds the data-out wire from sdo_o/sdo_oe_o.
 */
`timescale 1ns/100ps
`default_nettype none
module vsp_top
    import vsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic wr_pulse_o,
    output logic [ADDR_W-1:0] wr_addr_o,
    output logic [BYTE_W-1:0] wr_data_o
);
    vsp_mem_if mem_bus ();

    vsp_regmem u_mem (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .bus(mem_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // Link domain (serial clock)

    // Held in reset whenever chip select is high
    wire link_rst = ~rst_b_i | cs_b_i;

    logic [4:0] bit_cnt;
    logic [FRAME_BITS-2:0] rx_sh;
    logic [FRAME_BITS-1:0] rx_word;
    logic rx_tgl;
    logic [FRAME_BITS-1:0] tx_sh;
    logic [REG_W-1:0] tx_word;

    wire frame_end = (bit_cnt == CNT_LAST);
    wire cnt_run = (bit_cnt != CNT_FULL);

    // Bit counter, saturates after a full frame
    always_ff @(posedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt <= CNT_ZERO;
        end else if (cnt_run) begin
            bit_cnt <= bit_cnt + CNT_ONE;
        end
    end

    // Input shift, MSB first
    always_ff @(posedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            rx_sh <= '0;
        end else if (cnt_run) begin
            rx_sh <= {rx_sh[FRAME_BITS-3:0], sdi_i};
        end
    end

    // Whole frame held and announced by a toggle on the last edge
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_word <= WORD_RST;
            rx_tgl <= 1'h0;
        end else if (!cs_b_i && frame_end) begin
            rx_word <= {rx_sh, sdi_i};
            rx_tgl <= ~rx_tgl;
        end
    end

    // Output shift on falling edges; enable doubles as loaded flag
    always_ff @(negedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            sdo_o <= 1'h0;
            sdo_oe_o <= 1'h0;
            tx_sh <= '0;
        end else if (!sdo_oe_o) begin
            sdo_o <= tx_word[REG_W-1];
            sdo_oe_o <= 1'h1;
            tx_sh <= {tx_word[REG_W-2:0], 1'h0};
        end else begin
            sdo_o <= tx_sh[FRAME_BITS-1];
            tx_sh <= {tx_sh[FRAME_BITS-2:0], 1'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: frame event crossing

    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tgl_s1 <= 1'h0;
            tgl_s2 <= 1'h0;
            tgl_s3 <= 1'h0;
        end else begin
            tgl_s1 <= rx_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
        end
    end

    // Frame decode; the held word is stable once the toggle is seen
    wire frame_evt = tgl_s2 ^ tgl_s3;
    wire cmd_write = (rx_word[FLAG_POS] == WRITE_FLAG);
    wire [ADDR_W-1:0] cmd_addr = rx_word[ADDR_MSB:ADDR_LSB];
    wire [BYTE_W-1:0] cmd_data = rx_word[DATA_MSB:DATA_LSB];
    wire do_write = frame_evt & cmd_write;
    wire do_read = frame_evt & ~cmd_write;
    wire [1:0] lane = cmd_addr[0] ? BE_HIGH : BE_LOW;

    // Memory requests
    assign mem_bus.be = do_write ? lane : BE_NONE;
    assign mem_bus.waddr = cmd_addr[ADDR_W-1:1];
    assign mem_bus.wdata = {cmd_data, cmd_data};
    assign mem_bus.re = do_read;
    assign mem_bus.raddr = cmd_addr[ADDR_W-1:1];

    ////////////////////////////////////////////////////////////////////////
    // Read sequencing: returned word waits for the next frame

    vsp_state_t state;
    vsp_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            VSP_IDLE: begin
                if (do_read) begin
                    next_state = VSP_READ_WAIT;
                end
            end
            VSP_READ_WAIT: begin
                next_state = VSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= VSP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Reply word, quasi-static while the next frame shifts it out
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_word <= WORD_RST;
        end else if (state == VSP_READ_WAIT) begin
            tx_word <= mem_bus.rdata;
        end
    end

    // Write strobe for actions that follow a byte write
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_pulse_o <= 1'h0;
            wr_addr_o <= ADDR_RST;
            wr_data_o <= BYTE_RST;
        end else begin
            wr_pulse_o <= do_write;
            if (do_write) begin
                wr_addr_o <= cmd_addr;
                wr_data_o <= cmd_data;
            end
        end
    end
endmodule
`default_nettype wire

// File: shared/vsp_mem_if.sv
/*
 * Carrier between the port controller and its register memory.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface vsp_mem_if;
    import vsp_pkg::*;
    logic [1:0] be;
    logic [WADDR_W-1:0] waddr;
    logic [REG_W-1:0] wdata;
    logic re;
    logic [WADDR_W-1:0] raddr;
    logic [REG_W-1:0] rdata;
    modport ctrl (output be, output waddr, output wdata, output re, output raddr,
                  input rdata);
    modport mem (input be, input waddr, input wdata, input re, input raddr,
                 output rdata);
endinterface
`default_nettype wire

// File: shared/vsp_pkg.sv
/*
 * Constants and types for the serial slave register port.
 * Assumes a 16-bit frame (flag, 7-bit byte address, 8-bit data)
 * and 16-bit user registers written one byte at a time and read as whole words.
 */
package vsp_pkg;
    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam int REG_W = 16;
    localparam int WADDR_W = 6;
    localparam int REG_CNT = 64;
    localparam int FLAG_POS = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam int DATA_LSB = 0;
    localparam logic WRITE_FLAG = 1'h1;
    // Bit counter saturates at the frame length
    localparam logic [4:0] CNT_LAST = 5'h0F;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    // Byte lane enables: even address is the lower byte
    localparam logic [1:0] BE_LOW = 2'h1;
    localparam logic [1:0] BE_HIGH = 2'h2;
    localparam logic [1:0] BE_NONE = 2'h0;
    // Reset values
    localparam logic [REG_W-1:0] WORD_RST = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

    typedef enum logic {
        VSP_IDLE,
        VSP_READ_WAIT
    } vsp_state_t;
endpackage

// File: sim/vsp_checker.sv
/* Port checks for the serial slave.
   Assumes binding onto vsp_top. */
`timescale 1ns/100ps
`default_nettype none
module vsp_checker
    import vsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic sdi_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic wr_pulse_o,
    input wire logic [ADDR_W-1:0] wr_addr_o,
    input wire logic [BYTE_W-1:0] wr_data_o
);
    // Output enable follows chip select
    oe_cs_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cs_b_i |-> !sdo_oe_o) else $error("oe while deselected");
    oe_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !cs_b_i && !$past(cs_b_i) && $past(sdo_oe_o) |-> sdo_oe_o)
        else $error("oe dropped in frame");
    oe_run_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(sdo_oe_o) |-> sdo_oe_o [*8]) else $error("oe too short");
    sdo_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !sdo_oe_o |-> !sdo_o) else $error("sdo set while released");
    // Serial clock side
    oe_sclk_a: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        !cs_b_i |-> sdo_oe_o) else $error("no oe at rising edge");
    idle_sclk_a: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        cs_b_i |-> !sdo_oe_o) else $error("reacts when deselected");
    // Write strobe
    wr_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $changed(wr_addr_o) || $changed(wr_data_o) |-> wr_pulse_o)
        else $error("write outputs moved alone");
    pulse_one_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        wr_pulse_o |=> !wr_pulse_o [*8]) else $error("strobe too long");
endmodule
bind vsp_top vsp_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk_i),
    .cs_b_i(cs_b_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .wr_pulse_o(wr_pulse_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
`default_nettype wire

// File: sim/vsp_master.sv
/* Serial master model: clock idles high, 15 ns period in frames.
   Assumes the bench resolves the data-out wire. */
`timescale 1ns/100ps
`default_nettype none
module vsp_master (
    output logic sclk_o,
    output logic cs_b_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    // Idle lines
    initial begin
        sclk_o = 1'b1;
        cs_b_o = 1'b1;
        sdi_o = 1'b0;
    end
    // Frame of n bits, flag first, MSB first
    task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        cs_b_o = 1'b0;
        #5;
        for (int i = 15; i > 15 - n; i--) begin
            sclk_o = 1'b0;
            sdi_o = tx[i];
            #7.5 sclk_o = 1'b1;
            rx[i] = sdo_i;
            #7.5;
        end
        sdi_o = ~sdi_o; // Released line shows inverse
        #5 cs_b_o = 1'b1;
        #100;
    endtask
    // Clock activity while deselected
    task automatic noise();
        repeat (16) begin
            #7.5 sclk_o = 1'b0;
            sdi_o = 1'b1;
            #7.5 sclk_o = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// File: sim/vsp_top_tb.sv
/* Self-checking bench for vsp_top.
   Assumes vsp_master drives the link. */
`timescale 1ns/100ps
`default_nettype none
module vsp_top_tb
    import vsp_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b1;
    logic sclk, cs_b, sdi, sdo, sdo_oe, wr_pulse;
    logic [ADDR_W-1:0] wr_addr;
    logic [BYTE_W-1:0] wr_data;
    wire sdo_w = sdo_oe ? sdo : 1'bz;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_pulse = 0;
    always #5 clk_i = ~clk_i;
    vsp_master m (.sclk_o(sclk), .cs_b_o(cs_b), .sdi_o(sdi), .sdo_i(sdo_w));
    vsp_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .wr_pulse_o(wr_pulse),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    task automatic complete_run();
        $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Strobe count and hang limit
    always @(posedge clk_i) begin
        cycles++;
        if (wr_pulse === 1'b1) n_pulse++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic t_write(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] rx;
        int p;
        p = n_pulse;
        @(posedge clk_i) #1;
        m.xfer(16, {WRITE_FLAG, a, d}, rx);
        chk(16'(n_pulse - p), 16'h0001);
        chk({9'h000, wr_addr}, {9'h000, a});
        chk({8'h00, wr_data}, {8'h00, d});
    endtask
    // Chained reads: each reply lands in the next frame
    task automatic t_reads(input logic [6:0] a, input logic [15:0] ea,
        input logic [6:0] b, input logic [15:0] eb);
        logic [15:0] rx;
        int p;
        p = n_pulse;
        @(posedge clk_i) #1;
        m.xfer(16, {1'b0, a, 8'hFF}, rx);
        m.xfer(16, {1'b0, b, 8'h00}, rx);
        chk(rx, ea);
        m.xfer(16, {1'b0, b, 8'h5A}, rx);
        chk(rx, eb);
        chk(16'(n_pulse - p), 16'h0000);
    endtask
    // Short frame and deselected clocking change nothing
    task automatic t_refuse();
        logic [15:0] rx;
        int p;
        p = n_pulse;
        @(posedge clk_i) #1;
        m.xfer(15, {WRITE_FLAG, 7'h10, 8'h99}, rx);
        m.noise();
        repeat (10) @(posedge clk_i);
        chk(16'(n_pulse - p), 16'h0000);
    endtask
    // Reset falls after time zero so every reset process sees the edge
    initial begin
        #1 rst_b_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        repeat (3) @(posedge clk_i);
        t_write(7'h10, 8'h34);
        t_write(7'h11, 8'h12);
        t_write(7'h7F, 8'hCD);
        t_write(7'h7E, 8'hAB);
        t_reads(7'h10, 16'h1234, 7'h7F, 16'hCDAB);
        t_refuse();
        t_reads(7'h11, 16'h1234, 7'h7E, 16'hCDAB);
        complete_run();
    end
endmodule
`default_nettype wire
